// ---- rtl/hwpr_adder8.sv ----
// eight-bit page adder of the remapper
`timescale 1ns/1ps
module hwpr_adder8
(
    // operands
    input  wire logic [7:0] offset_in,
    input  wire logic [7:0] page_in,
    // result
    output logic [7:0]      sum_out
);

    // carry out of bit 7 is dropped: overflow wraps silently
    assign sum_out = offset_in + page_in;

endmodule // hwpr_adder8

// ---- rtl/hwpr_pkg.sv ----
// constants for the host window page remapper
package hwpr_pkg;

    // host i/o ports of the graphics controller index/data pair
    localparam logic [15:0] HWPR_PORT_INDEX     = 16'h03CE;
    localparam logic [15:0] HWPR_PORT_DATA      = 16'h03CF;

    // extension indices behind the data port
    localparam logic [7:0]  HWPR_IDX_EXT_CTRL   = 8'h0A;
    localparam logic [7:0]  HWPR_IDX_CONTROL    = 8'h0D;
    localparam logic [7:0]  HWPR_IDX_OFS_A      = 8'h0E;
    localparam logic [7:0]  HWPR_IDX_OFS_B      = 8'h0F;

    // extension access unlock and lock codes
    localparam logic [7:0]  HWPR_EXT_UNLOCK     = 8'hEC;
    localparam logic [7:0]  HWPR_EXT_LOCK       = 8'hCE;

    // remap control field positions and implemented-bit mask
    localparam int          HWPR_CTL_ENABLE_BIT = 0;
    localparam int          HWPR_CTL_SIZE_BIT   = 1;
    localparam int          HWPR_CTL_PAGES_BIT  = 2;
    localparam logic [7:0]  HWPR_CTL_MASK       = 8'h07;

    // reset values
    localparam logic [7:0]  HWPR_RST_BYTE       = 8'h00;
    localparam logic [7:0]  HWPR_RST_INDEX      = 8'h00;
    localparam logic        HWPR_RST_FLAG       = 1'b0;

    // host window: bits 23:17 of A0000h..BFFFFh
    localparam logic [6:0]  HWPR_WIN_TAG        = 7'h05;

    // window quarter codes from host bits 16:15
    localparam logic [1:0]  HWPR_Q_A0           = 2'h0;
    localparam logic [1:0]  HWPR_Q_A8           = 2'h1;

    // all-zero byte for locked and idle reads
    localparam logic [7:0]  HWPR_ZERO_BYTE      = 8'h00;

endpackage

// ---- rtl/hwpr_remapper.sv ----
// host window page remapper: extension registers and address translation
//
// Overview of operation
// - control register write-protected by general io bit
// - 128K window reaches up to 1024K memory
// - one 8-bit adder forms translated page
// - offset bit 0 aligns host bit 12
// - low 12 address bits pass straight through
// - page plus bits 15:12 or 14:12
// - host bits 23:16 never enter adder
// - adder overflow wraps, no flag raised
// - each offset reaches 1024K on 4K boundary
// - page-count bit picks one or two offsets
// - page-size bit: 0=32K, 1=64K
// - window region selects first or second offset
// - uncovered window regions pass unmodified
// - remap disabled means address passes unmodified
// - offset registers hold 8-bit added value
// - offsets at data port indices 0E, 0F
// - code EC enables extensions, reads one
// - code CE disables extensions, reads zero
//
// Usage notes
// - registers 0D, 0E and 0F take writes and read back only once the extension flag is set
// - the window match uses all 24 host bits: aliases above 1M pass
//   through untranslated
// - a request uses the control and offsets held before its edge, so
//   a register write and a request in one cycle see the old setting
// - the 8-bit sum wraps inside 1M and no overflow is reported
// - reserved control bits 7:3 are dropped on write and read as zero
// - ce_in low freezes every register, so a strobe in that cycle is lost
`timescale 1ns/1ps
module hwpr_remapper
(
    // clock, reset, enable
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    // host i/o register port
    input  wire logic [15:0] io_addr_in,
    input  wire logic        io_wr_in,
    input  wire logic        io_rd_in,
    input  wire logic [7:0]  io_wdata_in,
    output logic [7:0]       io_rdata_out,
    output logic             io_rvalid_out,
    // write-protect bit 4 of the general io control register
    input  wire logic        gen_io_wprot_in,
    // host memory access
    input  wire logic [23:0] host_addr_in,
    input  wire logic        host_req_in,
    // display memory side
    output logic [19:0]      disp_addr_out,
    output logic             disp_valid_out,
    output logic             disp_remapped_out,
    // status
    output logic             ext_enabled_out
);

    import hwpr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // register state

    logic [7:0]  index_r;
    logic [7:0]  index_nxt;
    logic        ext_flag_r;
    logic        ext_flag_nxt;
    logic [7:0]  control_r;
    logic [7:0]  control_nxt;
    logic [7:0]  offset_a_r;
    logic [7:0]  offset_a_nxt;
    logic [7:0]  offset_b_r;
    logic [7:0]  offset_b_nxt;
    logic [7:0]  rdata_r;
    logic [7:0]  rdata_nxt;
    logic        rvalid_r;
    logic [19:0] disp_addr_r;
    logic [19:0] disp_addr_nxt;
    logic        disp_valid_r;
    logic        disp_remap_r;

    ////////////////////////////////////////////////////////////////////////////
    // i/o port decode

    // only the index/data pair is decoded; any other port gets no answer
    wire         sel_index    = (io_addr_in == HWPR_PORT_INDEX);
    wire         sel_data     = (io_addr_in == HWPR_PORT_DATA);
    wire         wr_index     = io_wr_in && sel_index;
    wire         wr_data      = io_wr_in && sel_data;
    wire         rd_index     = io_rd_in && sel_index;
    wire         rd_data      = io_rd_in && sel_data;

    // index decode behind the data port
    wire         idx_ext_ctrl = (index_r == HWPR_IDX_EXT_CTRL);
    wire         idx_control  = (index_r == HWPR_IDX_CONTROL);
    wire         idx_ofs_a    = (index_r == HWPR_IDX_OFS_A);
    wire         idx_ofs_b    = (index_r == HWPR_IDX_OFS_B);

    // registers 0D, 0E and 0F are reachable only once unlocked; extension control 0A always is
    wire         wr_ext_ctrl  = wr_data && idx_ext_ctrl;
    // write protect is a level kept elsewhere, looked at on every control write
    wire         wr_control   = wr_data && idx_control && ext_flag_r && !gen_io_wprot_in;
    wire         wr_ofs_a     = wr_data && idx_ofs_a && ext_flag_r;
    wire         wr_ofs_b     = wr_data && idx_ofs_b && ext_flag_r;

    // unlock and lock codes; any other value leaves the flag alone
    wire         code_unlock  = (io_wdata_in == HWPR_EXT_UNLOCK);
    wire         code_lock    = (io_wdata_in == HWPR_EXT_LOCK);

    ////////////////////////////////////////////////////////////////////////////
    // register next values

    // one next-value process per register keeps every flop plain
    always_comb
    begin
        index_nxt = index_r;
        if (wr_index)
        begin
            index_nxt = io_wdata_in;
        end
    end

    always_comb
    begin
        ext_flag_nxt = ext_flag_r;
        if (wr_ext_ctrl && code_unlock)
        begin
            ext_flag_nxt = 1'b1;
        end
        else if (wr_ext_ctrl && code_lock)
        begin
            ext_flag_nxt = 1'b0;
        end
    end

    always_comb
    begin
        control_nxt = control_r;
        if (wr_control)
        begin
            // reserved bits 7:3 are not stored and read as zero
            control_nxt = io_wdata_in & HWPR_CTL_MASK;
        end
    end

    always_comb
    begin
        offset_a_nxt = offset_a_r;
        if (wr_ofs_a)
        begin
            offset_a_nxt = io_wdata_in;
        end
    end

    always_comb
    begin
        offset_b_nxt = offset_b_r;
        if (wr_ofs_b)
        begin
            offset_b_nxt = io_wdata_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data selection

    // extension control reads back only its flag, in bit 0
    wire [7:0]   ext_ctrl_rd  = {7'h00, ext_flag_r};
    wire [7:0]   control_rd   = ext_flag_r ? control_r  : HWPR_ZERO_BYTE;
    wire [7:0]   offset_a_rd  = ext_flag_r ? offset_a_r : HWPR_ZERO_BYTE;
    wire [7:0]   offset_b_rd  = ext_flag_r ? offset_b_r : HWPR_ZERO_BYTE;

    always_comb
    begin
        rdata_nxt = HWPR_ZERO_BYTE;
        // the index port reads back even while the extensions are locked
        if (rd_index)
        begin
            rdata_nxt = index_r;
        end
        else if (rd_data && idx_ext_ctrl)
        begin
            rdata_nxt = ext_ctrl_rd;
        end
        else if (rd_data && idx_control)
        begin
            rdata_nxt = control_rd;
        end
        else if (rd_data && idx_ofs_a)
        begin
            rdata_nxt = offset_a_rd;
        end
        else if (rd_data && idx_ofs_b)
        begin
            rdata_nxt = offset_b_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control fields

    // fields come from the stored byte, so a control write shows in the
    // translation from the next request onward
    wire         remap_en     = control_r[HWPR_CTL_ENABLE_BIT];
    wire         size_64k     = control_r[HWPR_CTL_SIZE_BIT];
    wire         two_pages    = control_r[HWPR_CTL_PAGES_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // window region decode

    // the full 24-bit address must fall in A0000h..BFFFFh to be remapped
    wire         in_window    = (host_addr_in[23:17] == HWPR_WIN_TAG);
    wire [1:0]   quarter      = host_addr_in[16:15];
    wire         q_a0         = (quarter == HWPR_Q_A0);
    wire         q_a8         = (quarter == HWPR_Q_A8);
    // upper half of the window: both the B0000h and B8000h quarters
    wire         q_upper      = quarter[1];

    // offset a: first 32K always, second 32K too with 64K pages
    wire         use_a        = q_a0 || (q_a8 && size_64k);
    // offset b: second 32K with two 32K pages, upper 64K with two 64K pages
    wire         use_b        = two_pages && ((q_a8 && !size_64k) || (q_upper && size_64k));

    // regions that no offset covers stay untranslated
    wire         covered      = use_a || use_b;
    wire         do_remap     = remap_en && in_window && covered;

    ////////////////////////////////////////////////////////////////////////////
    // translation datapath

    // a single adder serves both offsets, so only one is chosen here
    wire [7:0]   sel_offset   = use_b ? offset_b_r : offset_a_r;

    // page bits above the page-offset field; bits 23:16 never enter
    wire [7:0]   page_64k     = {4'h0, host_addr_in[15:12]};
    wire [7:0]   page_32k     = {5'h00, host_addr_in[14:12]};
    wire [7:0]   page_bits    = size_64k ? page_64k : page_32k;
    wire [7:0]   page_sum;

    hwpr_adder8 u_adder
    (
        .offset_in (sel_offset),
        .page_in   (page_bits),
        .sum_out   (page_sum)
    );

    // sum lands on bits 19:12, so any 4K boundary up to 1024K is a base
    wire [19:0]  remap_addr   = {page_sum, host_addr_in[11:0]};
    // untranslated accesses keep only the low 20 host bits
    wire [19:0]  pass_addr    = host_addr_in[19:0];

    always_comb
    begin
        // pass-through is the default, so uncovered regions need no case
        disp_addr_nxt = pass_addr;
        if (do_remap)
        begin
            disp_addr_nxt = remap_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register file flops

    // a write in a cycle with ce_in low is dropped, not deferred
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            index_r    <= HWPR_RST_INDEX;
            ext_flag_r <= HWPR_RST_FLAG;
            control_r  <= HWPR_RST_BYTE;
            offset_a_r <= HWPR_RST_BYTE;
            offset_b_r <= HWPR_RST_BYTE;
        end
        else if (ce_in)
        begin
            index_r    <= index_nxt;
            ext_flag_r <= ext_flag_nxt;
            control_r  <= control_nxt;
            offset_a_r <= offset_a_nxt;
            offset_b_r <= offset_b_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read return flops

    // read data falls back to zero after a cycle without a read, so a
    // stale byte is never taken for a fresh answer
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rdata_r  <= HWPR_RST_BYTE;
            rvalid_r <= 1'b0;
        end
        else if (ce_in)
        begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rd_index || rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // display address flops

    // one register stage: the address is held until the next request
    // valid is rewritten on every enabled edge, so it pulses once
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            disp_addr_r  <= 20'h00000;
            disp_valid_r <= 1'b0;
            disp_remap_r <= 1'b0;
        end
        else if (ce_in)
        begin
            disp_valid_r <= host_req_in;
            if (host_req_in)
            begin
                disp_addr_r  <= disp_addr_nxt;
                disp_remap_r <= do_remap;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // every output comes straight from a flop
    assign io_rdata_out      = rdata_r;
    assign io_rvalid_out     = rvalid_r;
    assign disp_addr_out     = disp_addr_r;
    assign disp_valid_out    = disp_valid_r;
    assign disp_remapped_out = disp_remap_r;
    assign ext_enabled_out   = ext_flag_r;

endmodule // hwpr_remapper

// ---- verification/hwpr_host_model.sv ----
// host processor model issuing display window accesses
`timescale 1ns/1ps
module hwpr_host_model
(
    // clock
    input  wire logic   ref_clk_in,
    // host memory access
    output logic [23:0] host_addr_out,
    output logic        host_req_out
);
    initial
    begin
        host_addr_out = 24'h000000;
        host_req_out  = 1'b0;
    end
    // called at a rising edge; software has the full window decoded
    task automatic go(input logic [23:0] a, input logic more);
        host_addr_out <= a;
        host_req_out  <= 1'b1;
        @(posedge ref_clk_in);
        if (!more)
        begin
            host_req_out  <= 1'b0;
            // a released bus must not look like a stale valid address
            host_addr_out <= ~a;
        end
    endtask
endmodule // hwpr_host_model

// ---- verification/hwpr_remapper_asserts.sv ----
// port-level assertion checker for the host window page remapper
`timescale 1ns/1ps
module hwpr_remapper_asserts
(
    // watched ports
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    input  wire logic [15:0] io_addr_in,
    input  wire logic        io_wr_in,
    input  wire logic        io_rd_in,
    input  wire logic [7:0]  io_wdata_in,
    input  wire logic [7:0]  io_rdata_out,
    input  wire logic        io_rvalid_out,
    input  wire logic [23:0] host_addr_in,
    input  wire logic        host_req_in,
    input  wire logic [19:0] disp_addr_out,
    input  wire logic        disp_valid_out,
    input  wire logic        disp_remapped_out,
    input  wire logic        ext_enabled_out
);
    import hwpr_pkg::*;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // index and data ports differ only in bit 0
    wire io_hit = io_addr_in[15:1] == HWPR_PORT_INDEX[15:1];
    wire hreq   = ce_in && host_req_in;
    sequence s_wr(a, d);
        ce_in && io_wr_in && io_addr_in == a && io_wdata_in == d;
    endsequence
    sequence s_unlock;
        s_wr(HWPR_PORT_INDEX, HWPR_IDX_EXT_CTRL) ##1 s_wr(HWPR_PORT_DATA, HWPR_EXT_UNLOCK);
    endsequence
    sequence s_lock;
        s_wr(HWPR_PORT_INDEX, HWPR_IDX_EXT_CTRL) ##1 s_wr(HWPR_PORT_DATA, HWPR_EXT_LOCK);
    endsequence
    ////////////////////////////////////////
    a_valid_pulse: assert property (ce_in |=> disp_valid_out == $past(host_req_in))
        else $error("display valid does not follow the request");
    a_low_bits_pass: assert property (hreq |=> disp_addr_out[11:0] == $past(host_addr_in[11:0]))
        else $error("low address bits altered");
    a_outside_pass: assert property (hreq && host_addr_in[23:17] != HWPR_WIN_TAG |=>
        disp_addr_out == $past(host_addr_in[19:0]) && !disp_remapped_out)
        else $error("address outside window altered");
    a_plain_pass: assert property (hreq ##1 !disp_remapped_out |->
        disp_addr_out == $past(host_addr_in[19:0]))
        else $error("untranslated address altered");
    a_read_answer: assert property (ce_in && io_rd_in && io_hit |=> io_rvalid_out)
        else $error("read of register port not answered");
    a_foreign_quiet: assert property (ce_in && !(io_rd_in && io_hit) |=> !io_rvalid_out)
        else $error("read valid without a port read");
    a_rdata_idle: assert property (ce_in && !io_rd_in |=> io_rdata_out == 8'h00)
        else $error("read data not cleared");
    a_ext_unlock: assert property (s_unlock |=> ext_enabled_out)
        else $error("unlock code did not open extensions");
    a_ext_lock: assert property (s_lock |=> !ext_enabled_out)
        else $error("lock code did not close extensions");
    a_ext_hold: assert property (ce_in && !io_wr_in |=> $stable(ext_enabled_out))
        else $error("extension flag moved without a write");
endmodule // hwpr_remapper_asserts

bind hwpr_remapper hwpr_remapper_asserts u_chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .ce_in(ce_in), .io_addr_in(io_addr_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in),
    .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out), .io_rvalid_out(io_rvalid_out),
    .host_addr_in(host_addr_in), .host_req_in(host_req_in), .disp_addr_out(disp_addr_out),
    .disp_valid_out(disp_valid_out), .disp_remapped_out(disp_remapped_out),
    .ext_enabled_out(ext_enabled_out));

// ---- verification/tb.sv ----
// self-checking testbench for the host window page remapper
`timescale 1ns/1ps
module tb;
    import hwpr_pkg::*;
    localparam logic [7:0] OFS_A = 8'h13;
    localparam logic [7:0] OFS_B = 8'hF5;
    logic        ref_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        ce_in = 1'b1;
    logic [15:0] io_addr_in = 16'h0000;
    logic        io_wr_in = 1'b0;
    logic        io_rd_in = 1'b0;
    logic [7:0]  io_wdata_in = 8'h00;
    logic        gen_io_wprot_in = 1'b0;
    logic [7:0]  io_rdata_out;
    logic        io_rvalid_out;
    logic [23:0] host_addr_in;
    logic        host_req_in;
    logic [19:0] disp_addr_out;
    logic        disp_valid_out;
    logic        disp_remapped_out;
    logic        ext_enabled_out;
    int          fails = 0;
    int          num_checks = 0;
    always #2 ref_clk_in = ~ref_clk_in;
    hwpr_remapper dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .io_addr_in(io_addr_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in),
        .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out), .io_rvalid_out(io_rvalid_out),
        .gen_io_wprot_in(gen_io_wprot_in), .host_addr_in(host_addr_in),
        .host_req_in(host_req_in), .disp_addr_out(disp_addr_out),
        .disp_valid_out(disp_valid_out), .disp_remapped_out(disp_remapped_out),
        .ext_enabled_out(ext_enabled_out));
    hwpr_host_model host (.ref_clk_in(ref_clk_in), .host_addr_out(host_addr_in),
        .host_req_out(host_req_in));
    ////////////////////////////////////////
    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // bus tasks start at a rising edge and end on one
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        io_addr_in  <= a;
        io_wdata_in <= d;
        io_wr_in    <= 1'b1;
        io_rd_in    <= 1'b0;
        @(posedge ref_clk_in);
    endtask
    task automatic rd(input logic [15:0] a, input logic [8:0] e);
        io_addr_in <= a;
        io_wr_in   <= 1'b0;
        io_rd_in   <= 1'b1;
        @(posedge ref_clk_in);
        io_rd_in <= 1'b0;
        @(negedge ref_clk_in);
        cmp({15'h0, io_rvalid_out, io_rdata_out}, {15'h0, e});
        @(posedge ref_clk_in);
    endtask
    task automatic put(input logic [7:0] i, input logic [7:0] d);
        wr(HWPR_PORT_INDEX, i);
        wr(HWPR_PORT_DATA, d);
        io_wr_in <= 1'b0;
        @(posedge ref_clk_in);
    endtask
    task automatic get(input logic [7:0] i, input logic [7:0] e);
        wr(HWPR_PORT_INDEX, i);
        rd(HWPR_PORT_DATA, {1'b1, e});
    endtask
    function automatic logic [20:0] exp_map(input logic [23:0] a, input logic [2:0] c);
        logic [1:0] q;
        logic       s;
        logic       hit_a;
        logic       hit_b;
        logic [7:0] pg;
        q = a[16:15];
        s = c[HWPR_CTL_SIZE_BIT];
        hit_a = q == 2'h0 || (q == 2'h1 && s);
        hit_b = c[HWPR_CTL_PAGES_BIT] && ((q == 2'h1 && !s) || (q[1] && s));
        // eight-bit sum, carry out is simply lost
        pg = (hit_b ? OFS_B : OFS_A) + (s ? {4'h0, a[15:12]} : {5'h00, a[14:12]});
        if (c[HWPR_CTL_ENABLE_BIT] && a[23:17] == HWPR_WIN_TAG && (hit_a || hit_b))
            return {1'b1, pg, a[11:0]};
        return {1'b0, a[19:0]};
    endfunction
    task automatic xl(input logic [23:0] a, input logic [2:0] c);
        host.go(a, 1'b0);
        @(negedge ref_clk_in);
        cmp({2'b0, disp_valid_out, disp_remapped_out, disp_addr_out}, {3'b001, exp_map(a, c)});
        @(posedge ref_clk_in);
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        rd(HWPR_PORT_INDEX, 9'h100);
        get(HWPR_IDX_EXT_CTRL, 8'h00);
        xl(24'h0A1234, 3'h0);
        put(HWPR_IDX_EXT_CTRL, HWPR_EXT_UNLOCK);
        get(HWPR_IDX_CONTROL, 8'h00);
        get(HWPR_IDX_OFS_A, 8'h00);
        get(HWPR_IDX_OFS_B, 8'h00);
    endtask
    task automatic t_ext();
        get(HWPR_IDX_EXT_CTRL, 8'h01);
        cmp({23'h0, ext_enabled_out}, 24'h1);
        put(HWPR_IDX_EXT_CTRL, HWPR_EXT_LOCK);
        get(HWPR_IDX_EXT_CTRL, 8'h00);
        cmp({23'h0, ext_enabled_out}, 24'h0);
        put(HWPR_IDX_OFS_A, 8'h77);
        put(HWPR_IDX_EXT_CTRL, 8'h55);
        get(HWPR_IDX_EXT_CTRL, 8'h00);
        get(HWPR_IDX_OFS_A, 8'h00);
        put(HWPR_IDX_EXT_CTRL, HWPR_EXT_UNLOCK);
        get(HWPR_IDX_OFS_A, 8'h00);
        put(HWPR_IDX_EXT_CTRL, 8'h55);
        get(HWPR_IDX_EXT_CTRL, 8'h01);
        rd(16'h03C4, 9'h000);
        get(8'h0B, 8'h00);
    endtask
    task automatic t_regs();
        put(HWPR_IDX_OFS_A, OFS_A);
        put(HWPR_IDX_OFS_B, OFS_B);
        get(HWPR_IDX_OFS_A, OFS_A);
        get(HWPR_IDX_OFS_B, OFS_B);
        put(HWPR_IDX_CONTROL, 8'hFF);
        get(HWPR_IDX_CONTROL, HWPR_CTL_MASK);
        put(HWPR_IDX_CONTROL, 8'h00);
        gen_io_wprot_in <= 1'b1;
        put(HWPR_IDX_CONTROL, 8'h05);
        get(HWPR_IDX_CONTROL, 8'h00);
        gen_io_wprot_in <= 1'b0;
        put(HWPR_IDX_CONTROL, 8'h05);
        get(HWPR_IDX_CONTROL, 8'h05);
    endtask
    task automatic t_map();
        for (int c = 0; c < 8; c++)
        begin
            put(HWPR_IDX_CONTROL, 8'(c));
            for (int q = 0; q < 4; q++)
                xl(24'h0A5ABC + 24'(q) * 24'h008000, 3'(c));
        end
        xl(24'hFA5ABC, 3'h7);
        xl(24'h0C5ABC, 3'h7);
        host.go(24'h0B1000, 1'b1);
        xl(24'h0A0FFF, 3'h7);
    endtask
    // ce_in low must freeze the registers and the display side
    task automatic t_hold();
        ce_in <= 1'b0;
        put(HWPR_IDX_OFS_A, 8'h00);
        host.go(24'h0A0000, 1'b0);
        @(negedge ref_clk_in);
        cmp({2'b0, disp_valid_out, disp_remapped_out, disp_addr_out},
            {3'b000, exp_map(24'h0A0FFF, 3'h7)});
        @(posedge ref_clk_in);
        ce_in <= 1'b1;
        get(HWPR_IDX_OFS_A, OFS_A);
    endtask
    // a reset in mid-run must clear what the earlier scenarios set
    task automatic t_rst();
        rst_in <= 1'b1;
        @(negedge ref_clk_in);
        cmp({ext_enabled_out, disp_valid_out, disp_remapped_out, io_rvalid_out, disp_addr_out},
            24'h000000);
        cmp({16'h0000, io_rdata_out}, 24'h000000);
        @(posedge ref_clk_in);
        rst_in <= 1'b0;
        get(HWPR_IDX_EXT_CTRL, 8'h00);
        put(HWPR_IDX_EXT_CTRL, HWPR_EXT_UNLOCK);
        get(HWPR_IDX_CONTROL, 8'h00);
        get(HWPR_IDX_OFS_A, 8'h00);
        get(HWPR_IDX_OFS_B, 8'h00);
        xl(24'h0A1234, 3'h0);
    endtask
    ////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_ext();
        t_regs();
        t_map();
        t_hold();
        t_rst();
        wrap_up();
    end
    // run needs well under a thousand cycles
    initial
    begin
        #20000;
        fails++;
        wrap_up();
    end
endmodule // tb
